// ### design/pld_regs_map.vh
// Register map, field positions, reset values and timing counts for the page 2 diagnostics bank
`ifndef PLD_REGS_MAP_VH
`define PLD_REGS_MAP_VH

`define PLD_PAGE_DIAG        3'h2
`define PLD_ADDR_FREQ        5'h15
`define PLD_ADDR_TDR         5'h16

`define PLD_FREQ_SAMPLE_BIT  15
`define PLD_FREQ_SELECT_BIT  8
`define PLD_FREQ_RESULT_MSB  7
`define PLD_FREQ_RESULT_LSB  0
`define PLD_FREQ_RESULT_RST  8'h00

`define PLD_REFLECTOMETRY_ENABLE_BIT   15
`define PLD_TDR_FAST_BIT     14
`define PLD_TDR_TXCH_BIT     13
`define PLD_TDR_SEND_BIT     11
`define PLD_TDR_WIDTH_MSB    10
`define PLD_TDR_WIDTH_LSB    8
`define PLD_TDR_LOW_MSB      7
`define PLD_TDR_LOW_LSB      0
`define PLD_TDR_LOW_RST      8'h20
`define PLD_TDR_RST          16'h0020

`define PLD_CLK_PERIOD_PS    50000
`define PLD_FAST_UNIT_PS     8000
`define PLD_SLOW_UNIT_PS     50000
`define PLD_CNT_W            8
// One clock spans a 50 ns unit at the 50 ns clock
`define PLD_SLOW_UNIT_CYC    8'h01
`define PLD_SLOW_FULL_CYC    8'h02
`define PLD_FAST_UNIT_CYC    8'h01
`define PLD_CNT_ONE          8'h01
`define PLD_WIDTH_OFF        3'h0
`define PLD_WIDTH_ONE        3'h1

`endif

// ### design/pld_pulse_gen.v
// TDR pulse timing: width counting, source selection and polarity alternation
`timescale 1ns/10ps
`include "pld_regs_map.vh"
module pld_pulse_gen (
	// Clock and reset
	input  wire       clk,
	input  wire       srst,
	// Control
	input  wire       start,
	input  wire       fastGen,
	input  wire [2:0] widthSel,
	// Pulse outputs
	output reg        fastPulse,
	output reg        fastNegative,
	output reg        slowPulse,
	output reg        slowFull,
	output wire       busy
);
	reg [`PLD_CNT_W-1:0] count_reg;
	reg                  polarity_reg;

	assign busy = (count_reg != {`PLD_CNT_W{1'b0}});

	always @(posedge clk) begin
		if (srst) begin
			count_reg <= {`PLD_CNT_W{1'b0}};
			polarity_reg <= 1'b0;
			fastPulse <= 1'b0;
			fastNegative <= 1'b0;
			slowPulse <= 1'b0;
			slowFull <= 1'b0;
		end else if (start && !busy && widthSel != `PLD_WIDTH_OFF) begin
			if (fastGen) begin
				// 8 ns units run in the transmitter; one clock here spans the burst
				count_reg <= `PLD_FAST_UNIT_CYC; // R08
				fastPulse <= 1'b1; // R08
				fastNegative <= polarity_reg; // R09
				polarity_reg <= ~polarity_reg; // R09
			end else begin
				// Only one or two 50 ns units exist on the link pulse path
				count_reg <= (widthSel == `PLD_WIDTH_ONE) ? `PLD_SLOW_UNIT_CYC
					: `PLD_SLOW_FULL_CYC; // R10
				slowPulse <= 1'b1; // R10
				slowFull <= (widthSel != `PLD_WIDTH_ONE); // R10
			end
		end else if (busy) begin
			count_reg <= count_reg - `PLD_CNT_ONE;
			if (count_reg == `PLD_CNT_ONE) begin
				fastPulse <= 1'b0;
				slowPulse <= 1'b0;
			end
		end
	end
endmodule

// ### design/pld_diag_regs.v
// Page 2 link diagnostics registers: frequency offset indication and TDR control
`timescale 1ns/10ps
`include "pld_regs_map.vh"
// What this block does
// (R01) Sample with select 0 fetches long-term offset
// (R02) Sample with select 1 fetches frequency control
// (R03) Sample request bit always reads zero
// (R04) Bits 14:9 ignore writes, read zero
// (R05) Result read-only, resets zero, loaded on sample
// (R06) Result is signed, about 5.16 ppm per count
// (R07) Reflectometry_enable forces power-up state for testing
// (R08) Fast generator uses 100 Mb transmitter, 8 ns
// (R09) Fast pulses alternate positive then negative
// (R10) Slow generator gives 50 or 100 ns pulse
// (R11) Host selects page 2 before access
// (R12) Transmit select: 0 transmit pair, 1 receive
// (R13) Result holds until next sample completes
// (R14) Host selects source, samples, then reads later
module pld_diag_regs (
	// Clock and reset
	input  wire        clk,
	input  wire        srst,
	// Management register access
	input  wire [2:0]  register_page_select,
	input  wire [4:0]  regAddr,
	input  wire        regWrite,
	input  wire        regRead,
	input  wire [15:0] regWdata,
	output reg  [15:0] regRdata,
	// Receive DSP values
	input  wire [7:0]  dspLongOffset,
	input  wire [7:0]  dspFreqControl,
	output reg         dspPoll,
	input  wire        dspReady,
	// Transceiver and TDR drive
	output wire        forceTestPowerUp,
	output wire        pulseOnRxPair,
	output wire        fastPulse,
	output wire        fastNegative,
	output wire        slowPulse,
	output wire        slowFull,
	output wire        tdrBusy
);
	// Sample handshake states
	localparam [2:0] SMP_IDLE = 3'h1;
	localparam [2:0] SMP_WAIT = 3'h2;
	localparam [2:0] SMP_POLL = 3'h4;

	// Pulse send sequencing states
	localparam [3:0] TDR_IDLE = 4'h1;
	localparam [3:0] TDR_ARM  = 4'h2;
	localparam [3:0] TDR_RUN  = 4'h4;
	localparam [3:0] TDR_DONE = 4'h8;

	// Frequency offset register
	reg  [7:0]  result_reg;
	reg  [7:0]  result_next;
	reg         select_reg;
	reg         select_next;
	reg         pendingSel_reg;
	reg         pendingSel_next;
	reg         dspPoll_next;
	reg  [2:0]  smpState_reg;
	reg  [2:0]  smpState_next;

	// Reflectometry control register
	reg  [15:0] tdr_reg;
	reg  [15:0] tdr_next;
	reg  [3:0]  tdrState_reg;
	reg  [3:0]  tdrState_next;
	reg  [15:0] regRdata_next;

	// Receive DSP synchroniser stages
	reg  [7:0]  dspLongS1_reg;
	reg  [7:0]  dspLongS2_reg;
	reg  [7:0]  dspCtlS1_reg;
	reg  [7:0]  dspCtlS2_reg;
	reg         dspReadyS1_reg;
	reg         dspReadyS2_reg;

	// Decoded strobes
	wire        wrFreq;
	wire        wrTdr;
	wire        rdFreq;
	wire        rdTdr;
	wire        sampleReq;
	wire        sendReq;
	wire        pulseArmOk;
	wire        pulseIdle;
	wire        pulseStart;
	wire [2:0]  widthField;

	// Page and address match shared by write and read paths
	function addrHit;
		input [2:0] page;
		input [4:0] addr;
		input [4:0] target;
		begin
			addrHit = (page == `PLD_PAGE_DIAG) && (addr == target); // R11
		end
	endfunction

	// Read image: trigger and spare bits always zero
	function [15:0] freqImage;
		input       sel;
		input [7:0] result;
		begin
			freqImage = 16'h0000; // R03 R04
			freqImage[`PLD_FREQ_SELECT_BIT] = sel;
			freqImage[`PLD_FREQ_RESULT_MSB:`PLD_FREQ_RESULT_LSB] = result;
		end
	endfunction

	// Width zero is a baseline run with no pulse
	function pulseAllowed;
		input [15:0] ctrl;
		begin
			pulseAllowed = ctrl[`PLD_REFLECTOMETRY_ENABLE_BIT]
				&& (ctrl[`PLD_TDR_WIDTH_MSB:`PLD_TDR_WIDTH_LSB] != `PLD_WIDTH_OFF);
		end
	endfunction

	// Other pages are ignored; the host selects the page first
	assign wrFreq    = regWrite && addrHit(register_page_select, regAddr, `PLD_ADDR_FREQ);
	assign wrTdr     = regWrite && addrHit(register_page_select, regAddr, `PLD_ADDR_TDR);
	assign rdFreq    = regRead && addrHit(register_page_select, regAddr, `PLD_ADDR_FREQ);
	assign rdTdr     = regRead && addrHit(register_page_select, regAddr, `PLD_ADDR_TDR);
	assign sampleReq = wrFreq && regWdata[`PLD_FREQ_SAMPLE_BIT];
	assign sendReq   = wrTdr && regWdata[`PLD_TDR_SEND_BIT];

	// DSP values live on another clock; two stages before use
	always @(posedge clk) begin
		if (srst) begin
			dspLongS1_reg <= 8'h00;
			dspLongS2_reg <= 8'h00;
		end else begin
			dspLongS1_reg <= dspLongOffset;
			dspLongS2_reg <= dspLongS1_reg;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			dspCtlS1_reg <= 8'h00;
			dspCtlS2_reg <= 8'h00;
		end else begin
			dspCtlS1_reg <= dspFreqControl;
			dspCtlS2_reg <= dspCtlS1_reg;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			dspReadyS1_reg <= 1'b0;
			dspReadyS2_reg <= 1'b0;
		end else begin
			dspReadyS1_reg <= dspReady;
			dspReadyS2_reg <= dspReadyS1_reg;
		end
	end

	// Source is the select value written in the same access
	always @* begin
		select_next = select_reg;
		if (wrFreq)
			select_next = regWdata[`PLD_FREQ_SELECT_BIT];
	end

	always @* begin
		smpState_next = smpState_reg;
		dspPoll_next = dspPoll;
		pendingSel_next = pendingSel_reg;
		result_next = result_reg; // R13
		case (smpState_reg)
			SMP_IDLE: begin
				dspPoll_next = 1'b0;
			end
			SMP_WAIT: begin
				// A ready left over from the last poll must fall first
				if (!dspReadyS2_reg)
					smpState_next = SMP_POLL;
			end
			SMP_POLL: begin
				if (dspReadyS2_reg) begin
					smpState_next = SMP_IDLE;
					dspPoll_next = 1'b0;
					// Raw two's-complement code, about 5.16 ppm per step
					if (pendingSel_reg)
						result_next = dspCtlS2_reg; // R02 R06
					else
						result_next = dspLongS2_reg; // R01 R06
				end
			end
			default: begin
				smpState_next = SMP_IDLE;
				dspPoll_next = 1'b0;
			end
		endcase
		// A new request restarts the poll, even mid-handshake
		if (sampleReq) begin
			dspPoll_next = 1'b1;
			pendingSel_next = regWdata[`PLD_FREQ_SELECT_BIT];
			smpState_next = dspReadyS2_reg ? SMP_WAIT : SMP_POLL;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			smpState_reg <= SMP_IDLE;
			dspPoll <= 1'b0;
			pendingSel_reg <= 1'b0;
			select_reg <= 1'b0;
			result_reg <= `PLD_FREQ_RESULT_RST; // R05
		end else begin
			smpState_reg <= smpState_next;
			dspPoll <= dspPoll_next;
			pendingSel_reg <= pendingSel_next;
			select_reg <= select_next;
			result_reg <= result_next; // R05 R13
		end
	end

	assign widthField = tdr_reg[`PLD_TDR_WIDTH_MSB:`PLD_TDR_WIDTH_LSB];
	assign pulseArmOk = pulseAllowed(tdr_reg); // R07
	assign pulseIdle  = !tdrBusy && !fastPulse && !slowPulse;
	// Pulses only while TDR mode holds the transceiver
	assign pulseStart = (tdrState_reg == TDR_ARM) && pulseArmOk && pulseIdle;

	always @* begin
		tdrState_next = tdrState_reg;
		case (tdrState_reg)
			TDR_IDLE: begin
				tdrState_next = TDR_IDLE;
			end
			TDR_ARM: begin
				if (!pulseArmOk)
					tdrState_next = TDR_DONE;
				else if (pulseIdle)
					tdrState_next = TDR_RUN;
			end
			TDR_RUN: begin
				if (pulseIdle)
					tdrState_next = TDR_DONE;
			end
			TDR_DONE: begin
				tdrState_next = TDR_IDLE;
			end
			default: begin
				tdrState_next = TDR_IDLE;
			end
		endcase
		if (sendReq)
			tdrState_next = TDR_ARM;
	end

	// Host write beats the self-clear landing in the same cycle
	always @* begin
		tdr_next = tdr_reg;
		if (tdrState_reg == TDR_DONE)
			tdr_next[`PLD_TDR_SEND_BIT] = 1'b0;
		if (wrTdr)
			tdr_next = regWdata;
	end

	always @(posedge clk) begin
		if (srst) begin
			tdr_reg <= `PLD_TDR_RST; // R07
			tdrState_reg <= TDR_IDLE;
		end else begin
			tdr_reg <= tdr_next;
			tdrState_reg <= tdrState_next;
		end
	end

	assign forceTestPowerUp = tdr_reg[`PLD_REFLECTOMETRY_ENABLE_BIT]; // R07
	assign pulseOnRxPair = tdr_reg[`PLD_TDR_TXCH_BIT]; // R12

	pld_pulse_gen u_pulse (
		.clk          (clk),
		.srst         (srst),
		.start        (pulseStart),
		.fastGen      (tdr_reg[`PLD_TDR_FAST_BIT]), // R08 R10
		.widthSel     (widthField),
		.fastPulse    (fastPulse),
		.fastNegative (fastNegative),
		.slowPulse    (slowPulse),
		.slowFull     (slowFull),
		.busy         (tdrBusy)
	);

	// Read data registered one cycle after the read strobe
	always @* begin
		regRdata_next = regRdata;
		if (rdFreq)
			regRdata_next = freqImage(select_reg, result_reg); // R03 R04
		else if (rdTdr)
			regRdata_next = tdr_reg;
		else if (regRead)
			regRdata_next = 16'h0000; // R11
	end

	always @(posedge clk) begin
		if (srst)
			regRdata <= 16'h0000;
		else
			regRdata <= regRdata_next;
	end
endmodule

// ### test/pld_diag_regs_properties.sv
// Port checks for the page 2 diagnostics registers
`timescale 1ns/10ps
module pld_diag_regs_properties (
	input wire logic        clk, srst, regWrite, regRead, dspPoll, dspReady,
	input wire logic        forceTestPowerUp, pulseOnRxPair,
	input wire logic [2:0]  register_page_select,
	input wire logic [4:0]  regAddr,
	input wire logic [15:0] regWdata, regRdata
);
	wire pg = register_page_select == 3'h2;
	wire smp = regWrite && pg && regAddr == 5'h15 && regWdata[15];
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence sSmp; smp; endsequence
	sequence sWrT; regWrite && pg && regAddr == 5'h16; endsequence
	AST_RD_RSVD: assert property (regRead && pg && regAddr == 5'h15 |=> !regRdata[15:9])
		else $error("rsvd bits set");
	AST_BAD_PAGE: assert property (regRead && !pg |=> regRdata == 16'h0000)
		else $error("off page read");
	AST_POLL: assert property (sSmp |=> dspPoll)
		else $error("no poll");
	AST_POLL_SRC: assert property ($rose(dspPoll) |-> $past(smp))
		else $error("stray poll");
	AST_POLL_END: assert property (dspPoll && dspReady |-> ##[1:5] !dspPoll)
		else $error("poll stuck");
	AST_EN: assert property (sWrT |=> forceTestPowerUp == $past(regWdata[15]))
		else $error("enable bad");
	AST_RX: assert property (sWrT |=> pulseOnRxPair == $past(regWdata[13]))
		else $error("pair bad");
	AST_HOLD: assert property (!regRead |=> $stable(regRdata))
		else $error("rdata moved");
endmodule
bind pld_diag_regs pld_diag_regs_properties pld_diag_regs_properties_i (.*);

// ### test/pld_dsp_model.sv
// Receive DSP stand-in answering offset polls after a set latency
`timescale 1ns/10ps
module pld_dsp_model (
	input wire logic        clk, dspPoll,
	input wire logic [3:0]  lat,
	input wire logic [7:0]  lv, cv,
	output logic     [7:0]  dspLongOffset, dspFreqControl,
	output logic            dspReady = 1'b0
);
	logic [3:0] cnt = 4'h0;
	// Values flip outside a poll so a stale capture shows up
	assign dspLongOffset = dspPoll ? lv : ~lv;
	assign dspFreqControl = dspPoll ? cv : ~cv;
	always @(posedge clk) begin
		cnt <= dspPoll ? cnt + 4'h1 : 4'h0;
		dspReady <= dspPoll && cnt >= lat;
	end
endmodule

// ### test/pld_diag_regs_tb_top.sv
// Self-checking bench for the page 2 diagnostics registers
`timescale 1ns/10ps
module pld_diag_regs_tb_top;
	logic clk = 0, srst = 1, regWrite = 0, regRead = 0, full = 0;
	logic dspPoll, dspReady, forceTestPowerUp, pulseOnRxPair;
	logic fastPulse, fastNegative, slowPulse, slowFull, tdrBusy;
	logic [2:0] register_page_select = 3'h2;
	logic [4:0] regAddr = 5'h00;
	logic [15:0] regWdata = 16'h0000, regRdata, w;
	logic [7:0] lv = 8'h00, cv = 8'h00, dspLongOffset, dspFreqControl;
	logic [3:0] lat = 4'h3;
	logic [2:0] wd [4] = '{3'h2, 3'h3, 3'h1, 3'h2};
	int n_mismatch = 0, cmp_count = 0, seed = 42, i, k, nf, ns;
	always #25 clk = ~clk;
	pld_diag_regs pld_diag_regs_i (
		.clk(clk), .srst(srst), .register_page_select(register_page_select), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
		.dspLongOffset(dspLongOffset), .dspFreqControl(dspFreqControl),
		.dspPoll(dspPoll), .dspReady(dspReady),
		.forceTestPowerUp(forceTestPowerUp), .pulseOnRxPair(pulseOnRxPair),
		.fastPulse(fastPulse), .fastNegative(fastNegative), .slowPulse(slowPulse),
		.slowFull(slowFull), .tdrBusy(tdrBusy)
	);
	pld_dsp_model pld_dsp_model_i (
		.clk(clk), .dspPoll(dspPoll), .lat(lat), .lv(lv), .cv(cv),
		.dspLongOffset(dspLongOffset), .dspFreqControl(dspFreqControl), .dspReady(dspReady)
	);
	task chk(input logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h want %h", $time, s, e);
		end
	endtask
	task final_report;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task acc(input logic r, input logic [4:0] a, input logic [15:0] d);
		@(negedge clk) {regRead, regWrite, regAddr, regWdata} = {r, !r, a, d};
		@(negedge clk) {regRead, regWrite} = 2'b00;
	endtask
	function logic [15:0] frq(input logic s, input logic [7:0] l, c);
		return {7'h00, s, s ? c : l};
	endfunction
	initial begin
		repeat (20) @(negedge clk);
		srst = 0;
		acc(1, 5'h15, 0);
		chk(regRdata, 16'h0000);
		for (i = 0; i < 8; i++) begin
			lv = i == 0 ? 8'h7F : i == 1 ? 8'h80 : 8'($random(seed));
			cv = i < 2 ? lv : 8'($random(seed));
			lat = 4'(3 + i);
			// Select rides in the same write as the request
			acc(0, 5'h15, {7'h7F, i[0], 8'hFF});
			chk(dspPoll, 1'b1);
			for (k = 0; k < 40 && dspPoll; k++) @(negedge clk);
			if (dspPoll) begin
				n_mismatch++;
				final_report;
			end
			acc(1, 5'h15, 0);
			chk(regRdata, frq(i[0], lv, cv));
			acc(1, 5'h15, 0);
			chk(regRdata, frq(i[0], lv, cv));
		end
		w = 16'($random(seed)) & 16'hF7FF;
		acc(0, 5'h16, w);
		acc(1, 5'h16, 0);
		chk(regRdata, w);
		chk({forceTestPowerUp, pulseOnRxPair}, {w[15], w[13]});
		register_page_select = 3'h1;
		acc(0, 5'h16, ~w);
		acc(1, 5'h16, 0);
		chk(regRdata, 16'h0000);
		register_page_select = 3'h2;
		acc(1, 5'h16, 0);
		chk(regRdata, w);
		for (i = 0; i < 4; i++) begin
			w = {1'b1, i < 2, 2'b00, 1'b1, wd[i], 8'h20};
			nf = 0;
			ns = 0;
			acc(0, 5'h16, w);
			for (k = 0; k < 16; k++) begin
				@(negedge clk);
				nf += fastPulse;
				ns += slowPulse;
				if (slowPulse) full = slowFull;
			end
			chk(16'(nf), i < 2);
			chk(tdrBusy, 1'b0);
			chk(16'(ns), i < 2 ? 0 : wd[i]);
			if (i < 2) chk(fastNegative, i == 1);
			else chk(full, wd[i] == 3'h2);
			acc(1, 5'h16, 0);
			chk(regRdata, w & 16'hF7FF);
		end
		// Send without TDR mode: no pulse, bit still self-clears
		w = 16'h0920;
		nf = 0;
		acc(0, 5'h16, w);
		for (k = 0; k < 8; k++) begin
			@(negedge clk);
			nf += fastPulse + slowPulse;
		end
		chk(16'(nf), 16'h0000);
		acc(1, 5'h16, 0);
		chk(regRdata, 16'h0120);
		final_report;
	end
endmodule
